// File: hw/two_wire_pkg.sv
package two_wire_pkg;
	localparam logic [2:0] ADDR_TX_BUFFER      = 3'h0;
	localparam logic [2:0] ADDR_RX_BUFFER      = 3'h1;
	localparam logic [2:0] ADDR_BIT_RATE       = 3'h2;
	localparam logic [2:0] ADDR_SERIAL_MODE    = 3'h3;
	localparam logic [2:0] ADDR_CHANNEL_CTRL0  = 3'h4;
	localparam logic [2:0] ADDR_TX_RX_CONTROL  = 3'h5;
	localparam logic [2:0] ADDR_TWO_WIRE_CTRL  = 3'h6;
	localparam logic [2:0] ADDR_RX_INT_CONTROL = 3'h7;

	localparam logic [2:0] FUNCTION_TWO_WIRE   = 3'h2;
	localparam int         MODE_EXT_CLOCK_BIT  = 3;
	localparam int         CC0_SHIFT_EMPTY_BIT = 3;
	localparam int         CC0_ORDER_BIT       = 7;
	localparam int         TRC_TX_ALLOW_BIT    = 0;
	localparam int         TRC_TX_EMPTY_BIT    = 1;
	localparam int         TRC_RX_ALLOW_BIT    = 2;
	localparam int         TRC_RX_DONE_BIT     = 3;
	localparam int         TWC_MODE_BIT        = 0;
	localparam int         TWC_ARB_TIMING_BIT  = 1;
	localparam int         TWC_PHASE_BIT       = 2;
	localparam int         TWC_ACK_BIT         = 3;
	localparam int         TWC_DELAY_LSB       = 4;
	localparam int         RIC_PENDING_BIT     = 3;
	localparam int         RXB_ACK_BIT         = 8;
	localparam int         RXB_ARB_BIT         = 11;
	localparam int         RXB_OVERRUN_BIT     = 12;

	localparam logic [7:0] SERIAL_MODE_RESET   = 8'h00;
	localparam logic [7:0] CHANNEL_CTRL_RESET  = 8'h00;
	localparam logic [7:0] TWO_WIRE_CTRL_RESET = 8'h00;
	localparam logic [7:0] BIT_RATE_RESET      = 8'h00;
	localparam logic [7:0] CC0_WRITE_MASK      = 8'hf7;

	localparam logic [1:0] SOURCE_DIV1         = 2'h0;
	localparam logic [1:0] SOURCE_DIV2         = 2'h1;
	localparam logic [1:0] SOURCE_DIV8         = 2'h2;
	localparam logic [1:0] SOURCE_DIV32        = 2'h3;

	localparam logic [3:0] BITS_PER_UNIT       = 4'h9;
	localparam logic [3:0] OVERRUN_BIT_COUNT   = 4'h7;
	localparam int         CLK_PERIOD_NS       = 40;
	localparam int         SETTLE_TIME_NS      = 80;
	localparam logic [1:0] SETTLE_CYCLES       =
		2'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOW  = 2'h1,
		ST_HIGH = 2'h3,
		ST_DONE = 2'h2
	} bit_state_type;
endpackage

// File: hw/two_wire_clock_gen.sv
`timescale 1ns/100ps
module two_wire_clock_gen (
	// system
	input  logic       clk_sys,
	input  logic       reset_n,
	// control
	input  logic       enable,
	input  logic       restart,
	input  logic [1:0] source_select,
	input  logic [7:0] divider,
	// ticks
	output logic       src_tick,
	output logic       line_tick
);
	logic [4:0] prescale;
	logic [7:0] count;

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			prescale <= 5'h00;
		else
			prescale <= prescale + 5'h01;
	end

	// count source choice
	always_comb
	begin
		case (source_select)
			two_wire_pkg::SOURCE_DIV1:  src_tick = 1'b1;
			two_wire_pkg::SOURCE_DIV2:  src_tick = prescale[0];
			two_wire_pkg::SOURCE_DIV8:  src_tick = &prescale[2:0];
			two_wire_pkg::SOURCE_DIV32: src_tick = &prescale;
			default:                    src_tick = 1'b1;
		endcase
	end

	// half period of n+1 source ticks
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || !enable || restart)
		begin
			count     <= divider;
			line_tick <= 1'b0;
		end
		else if (src_tick)
		begin
			if (count == 8'h00)
			begin
				count     <= divider;
				line_tick <= 1'b1;
			end
			else
			begin
				count     <= count - 8'h01;
				line_tick <= 1'b0;
			end
		end
		else
			line_tick <= 1'b0;
	end
endmodule

// File: hw/sda_delay_line.sv
`timescale 1ns/100ps
module sda_delay_line (
	// system
	input  logic       clk_sys,
	input  logic       reset_n,
	// control
	input  logic       src_tick,
	input  logic [2:0] delay_select,
	// data
	input  logic       data_in,
	output logic       data_out
);
	logic [7:0] stage;

	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_stage
			always_ff @(posedge clk_sys)
			begin
				if (!reset_n)
					stage[g] <= 1'b1;
				else if (src_tick)
					stage[g] <= (g == 0) ? data_in : stage[(g == 0) ? 0 : g - 1];
			end
		end
	endgenerate

	// select 1..7 gives 2..8 source ticks
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			data_out <= 1'b1;
		else if (delay_select == 3'h0)
			data_out <= data_in;
		else
			data_out <= stage[delay_select];
	end
endmodule

// File: hw/two_wire_serial_mode.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module two_wire_serial_mode (
	// system
	input  logic        clk_sys,
	input  logic        reset_n,
	// register port
	input  logic [2:0]  reg_addr,
	input  logic [7:0]  reg_wdata,
	input  logic        reg_write,
	input  logic        reg_read,
	output logic [15:0] reg_rdata,
	// clock line
	input  logic        scl_in,
	output logic        scl_out,
	output logic        scl_oe_n,
	// data line
	input  logic        sda_in,
	output logic        sda_out,
	output logic        sda_oe_n,
	// event request
	output logic        irq_request
);
	two_wire_pkg::bit_state_type state;

	logic [7:0] tx_buffer;
	logic       tx_empty;
	logic [7:0] bit_rate_divider;
	logic [7:0] serial_mode_reg;
	logic [7:0] channel_control_zero;
	logic [7:0] two_wire_control;
	logic       tx_allow;
	logic       rx_allow;
	logic       rx_complete;
	logic       interrupt_pending;
	logic [7:0] rx_data;
	logic       rx_ack;
	logic       arbitration_lost_flag;
	logic       overrun_flag;
	logic       overrun_byte;
	logic       arb_hold;
	logic [3:0] bit_cnt;
	logic [8:0] tx_shift;
	logic [8:0] rx_shift;
	logic [7:0] tx_ordered;
	logic [7:0] rx_ordered;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_prev;
	logic       sda_prev;
	logic [1:0] scl_low_cnt;
	logic       scl_pull;
	logic       phase_wait;
	logic       src_tick;
	logic       line_tick;
	logic       sda_delayed;

	logic wr_tx;
	logic wr_brg;
	logic wr_mode;
	logic wr_cc0;
	logic wr_trc;
	logic wr_twc;
	logic wr_ric;
	logic rd_rxb;
	logic mode_active;
	logic clock_external;
	logic master_run;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic scl_settled_low;
	logic start_det;
	logic stop_det;
	logic start_ok;
	logic load;
	logic arb_event;
	logic ovr_event;
	logic byte_done;

	// register decode
	assign wr_tx   = reg_write && (reg_addr == two_wire_pkg::ADDR_TX_BUFFER);
	assign wr_brg  = reg_write && (reg_addr == two_wire_pkg::ADDR_BIT_RATE);
	assign wr_mode = reg_write && (reg_addr == two_wire_pkg::ADDR_SERIAL_MODE);
	assign wr_cc0  = reg_write && (reg_addr == two_wire_pkg::ADDR_CHANNEL_CTRL0);
	assign wr_trc  = reg_write && (reg_addr == two_wire_pkg::ADDR_TX_RX_CONTROL);
	assign wr_twc  = reg_write && (reg_addr == two_wire_pkg::ADDR_TWO_WIRE_CTRL);
	assign wr_ric  = reg_write && (reg_addr == two_wire_pkg::ADDR_RX_INT_CONTROL);
	assign rd_rxb  = reg_read && (reg_addr == two_wire_pkg::ADDR_RX_BUFFER);

	assign mode_active = (serial_mode_reg[2:0] == two_wire_pkg::FUNCTION_TWO_WIRE)
		&& two_wire_control[two_wire_pkg::TWC_MODE_BIT];
	assign clock_external = serial_mode_reg[two_wire_pkg::MODE_EXT_CLOCK_BIT];
	assign master_run     = mode_active && !clock_external;

	// line sampling
	assign scl_s    = scl_sync[1];
	assign sda_s    = sda_sync[1];
	assign scl_rise = scl_s && !scl_prev;
	assign scl_fall = !scl_s && scl_prev;
	assign scl_settled_low = (scl_low_cnt == two_wire_pkg::SETTLE_CYCLES);
	assign start_det = mode_active && scl_s && scl_prev && sda_prev && !sda_s;
	assign stop_det  = mode_active && scl_s && scl_prev && !sda_prev && sda_s;

	// transfer start: allow set and buffer holding data
	assign start_ok = mode_active && (state == two_wire_pkg::ST_IDLE)
		&& tx_allow && !tx_empty && (scl_s || !clock_external);
	assign load      = start_ok;
	assign byte_done = (state == two_wire_pkg::ST_DONE);
	assign arb_event = master_run && (state == two_wire_pkg::ST_LOW) && scl_rise
		&& sda_oe_n && !sda_s && (bit_cnt != two_wire_pkg::BITS_PER_UNIT - 4'h1);
	assign ovr_event = (state == two_wire_pkg::ST_LOW) && scl_rise && rx_allow
		&& rx_complete && (bit_cnt == two_wire_pkg::OVERRUN_BIT_COUNT);

	// open drain: output level always low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_order
			assign tx_ordered[g] = channel_control_zero[two_wire_pkg::CC0_ORDER_BIT]
				? tx_buffer[g] : tx_buffer[7 - g];
			assign rx_ordered[g] = channel_control_zero[two_wire_pkg::CC0_ORDER_BIT]
				? rx_shift[g + 1] : rx_shift[8 - g];
		end
	endgenerate

	two_wire_clock_gen u_clock_gen (
		.clk_sys       (clk_sys),
		.reset_n       (reset_n),
		.enable        (master_run),
		.restart       (load),
		.source_select (channel_control_zero[1:0]),
		.divider       (bit_rate_divider),
		.src_tick      (src_tick),
		.line_tick     (line_tick)
	);

	sda_delay_line u_sda_delay (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.src_tick     (src_tick),
		.delay_select (two_wire_control[two_wire_pkg::TWC_DELAY_LSB +: 3]),
		.data_in      (tx_shift[8]),
		.data_out     (sda_delayed)
	);

	// synchronisers and edge history
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_s;
			sda_prev <= sda_s;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || scl_s)
			scl_low_cnt <= 2'h0;
		else if (!scl_settled_low)
			scl_low_cnt <= scl_low_cnt + 2'h1;
	end

	// software registers
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			tx_buffer            <= 8'h00;
			bit_rate_divider     <= two_wire_pkg::BIT_RATE_RESET;
			serial_mode_reg      <= two_wire_pkg::SERIAL_MODE_RESET;
			channel_control_zero <= two_wire_pkg::CHANNEL_CTRL_RESET;
			two_wire_control     <= two_wire_pkg::TWO_WIRE_CTRL_RESET;
			tx_allow             <= 1'b0;
			rx_allow             <= 1'b0;
		end
		else
		begin
			if (wr_tx)
				tx_buffer <= reg_wdata;
			if (wr_brg)
				bit_rate_divider <= reg_wdata;
			if (wr_mode)
				serial_mode_reg <= reg_wdata;
			// flow control bits are stored only
			if (wr_cc0)
				channel_control_zero <= reg_wdata & two_wire_pkg::CC0_WRITE_MASK;
			if (wr_twc)
				two_wire_control <= reg_wdata;
			if (wr_trc)
			begin
				tx_allow <= reg_wdata[two_wire_pkg::TRC_TX_ALLOW_BIT];
				rx_allow <= reg_wdata[two_wire_pkg::TRC_RX_ALLOW_BIT];
			end
		end
	end

	// buffer empty flag
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			tx_empty <= 1'b1;
		else if (wr_tx)
			tx_empty <= 1'b0;
		else if (load)
			tx_empty <= 1'b1;
	end

	// bit sequencer, driven by sampled line edges
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || !mode_active)
		begin
			state   <= two_wire_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
		end
		else
		begin
			case (state)
				two_wire_pkg::ST_IDLE:
					if (start_ok)
					begin
						state   <= two_wire_pkg::ST_LOW;
						bit_cnt <= 4'h0;
					end
				two_wire_pkg::ST_LOW:
					if (scl_rise)
					begin
						state   <= two_wire_pkg::ST_HIGH;
						bit_cnt <= bit_cnt + 4'h1;
					end
				two_wire_pkg::ST_HIGH:
					if (scl_fall)
						state <= (bit_cnt == two_wire_pkg::BITS_PER_UNIT)
							? two_wire_pkg::ST_DONE : two_wire_pkg::ST_LOW;
				two_wire_pkg::ST_DONE:
					state <= two_wire_pkg::ST_IDLE;
				default:
					state <= two_wire_pkg::ST_IDLE;
			endcase
		end
	end

	// shift registers: next bit on fall, sample on rise
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			tx_shift <= 9'h1ff;
			rx_shift <= 9'h1ff;
		end
		else if (load)
			tx_shift <= {tx_ordered, two_wire_control[two_wire_pkg::TWC_ACK_BIT]};
		else if (byte_done || !mode_active)
			tx_shift <= 9'h1ff;
		else if (state == two_wire_pkg::ST_HIGH && scl_fall)
			tx_shift <= {tx_shift[7:0], 1'b1};
		else if (state == two_wire_pkg::ST_LOW && scl_rise)
			rx_shift <= {rx_shift[7:0], sda_s};
	end

	// master clock: pull, then release after a line tick
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || !master_run || byte_done)
		begin
			scl_pull   <= 1'b0;
			phase_wait <= 1'b0;
		end
		else if (load)
		begin
			scl_pull   <= 1'b1;
			phase_wait <= two_wire_control[two_wire_pkg::TWC_PHASE_BIT];
		end
		else if (line_tick)
		begin
			if (state == two_wire_pkg::ST_LOW && scl_pull)
			begin
				if (phase_wait)
					phase_wait <= 1'b0;
				else
					scl_pull <= 1'b0;
			end
			else if (state == two_wire_pkg::ST_HIGH && !scl_pull && scl_s)
				scl_pull <= 1'b1;
		end
	end

	assign scl_oe_n = !scl_pull;

	// in two-wire mode the data pin changes only once clock is settled low; leaving the mode releases it at once
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || !mode_active)
			sda_oe_n <= 1'b1;
		else if (scl_settled_low)
			sda_oe_n <= sda_delayed | arb_hold;
	end

	// arbitration loss
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			arb_hold              <= 1'b0;
			arbitration_lost_flag <= 1'b0;
		end
		else
		begin
			if (arb_event)
				arb_hold <= 1'b1;
			else if (load)
				arb_hold <= 1'b0;
			if (arb_event && !two_wire_control[two_wire_pkg::TWC_ARB_TIMING_BIT])
				arbitration_lost_flag <= 1'b1;
			else if (byte_done && arb_hold)
				arbitration_lost_flag <= 1'b1;
			else if (load)
				arbitration_lost_flag <= 1'b0;
		end
	end

	// receive buffer and overrun
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			rx_data      <= 8'h00;
			rx_ack       <= 1'b0;
			rx_complete  <= 1'b0;
			overrun_flag <= 1'b0;
			overrun_byte <= 1'b0;
		end
		else
		begin
			if (byte_done && rx_allow)
			begin
				rx_data <= rx_ordered;
				rx_ack  <= rx_shift[0];
			end
			if (byte_done && rx_allow)
				rx_complete <= 1'b1;
			else if (rd_rxb)
				rx_complete <= 1'b0;
			if (ovr_event)
				overrun_flag <= 1'b1;
			else if (wr_trc && !reg_wdata[two_wire_pkg::TRC_RX_ALLOW_BIT])
				overrun_flag <= 1'b0;
			if (ovr_event)
				overrun_byte <= 1'b1;
			else if (load)
				overrun_byte <= 1'b0;
		end
	end

	// event request: start, stop, ack or nack of a byte that did not overrun
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			interrupt_pending <= 1'b0;
		else if (start_det || stop_det || (byte_done && !overrun_byte))
			interrupt_pending <= 1'b1;
		else if (wr_ric && !reg_wdata[two_wire_pkg::RIC_PENDING_BIT])
			interrupt_pending <= 1'b0;
	end

	assign irq_request = interrupt_pending;

	// read data, one cycle after strobe
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n || !reg_read)
			reg_rdata <= 16'h0000;
		else
		begin
			case (reg_addr)
				two_wire_pkg::ADDR_RX_BUFFER:
					reg_rdata <= {3'h0, overrun_flag, arbitration_lost_flag,
						2'h0, rx_ack, rx_data};
				two_wire_pkg::ADDR_SERIAL_MODE:
					reg_rdata <= {8'h00, serial_mode_reg};
				two_wire_pkg::ADDR_CHANNEL_CTRL0:
					reg_rdata <= {8'h00, channel_control_zero[7:4],
						state == two_wire_pkg::ST_IDLE, channel_control_zero[2:0]};
				two_wire_pkg::ADDR_TX_RX_CONTROL:
					reg_rdata <= {12'h000, rx_complete, rx_allow, tx_empty, tx_allow};
				two_wire_pkg::ADDR_TWO_WIRE_CTRL:
					reg_rdata <= {8'h00, two_wire_control};
				two_wire_pkg::ADDR_RX_INT_CONTROL:
					reg_rdata <= {12'h000, interrupt_pending, 3'h0};
				default:
					reg_rdata <= 16'h0000;
			endcase
		end
	end

	default clocking cb_sys @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_eighth_rise;
		state == two_wire_pkg::ST_LOW && scl_rise && bit_cnt == 4'h7;
	endsequence

	sequence s_ninth_fall;
		state == two_wire_pkg::ST_HIGH && scl_fall && bit_cnt == 4'h9;
	endsequence

	property p_mode_gate;
		!mode_active |=> state == two_wire_pkg::ST_IDLE;
	endproperty
	a_mode_gate: assert property (p_mode_gate)
		else $error("sequencer left idle outside two-wire mode");

	property p_sda_still_high;
		scl_s && scl_prev |=> $stable(sda_oe_n) || !mode_active;
	endproperty
	a_sda_still_high: assert property (p_sda_still_high)
		else $error("data pin moved while clock high");

	property p_byte_len;
		s_ninth_fall |=> byte_done ##1 state == two_wire_pkg::ST_IDLE;
	endproperty
	a_byte_len: assert property (p_byte_len)
		else $error("unit did not end after nine clocks");

	property p_start_gate;
		$rose(state == two_wire_pkg::ST_LOW) && $past(state) == two_wire_pkg::ST_IDLE
			|-> $past(tx_allow) && !$past(tx_empty);
	endproperty
	a_start_gate: assert property (p_start_gate)
		else $error("transfer began without allow or data");

	property p_overrun;
		s_eighth_rise and (rx_allow && rx_complete) |=> overrun_flag;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun flag missed");

	property p_event_request;
		start_det || stop_det |=> irq_request;
	endproperty
	a_event_request: assert property (p_event_request)
		else $error("condition did not raise request");

	property p_ack_store;
		byte_done && rx_allow |=> rx_ack == $past(rx_shift[0]) && rx_complete;
	endproperty
	a_ack_store: assert property (p_ack_store)
		else $error("ack level not stored in bit eight");

	property p_arb_flag;
		arb_event && !two_wire_control[two_wire_pkg::TWC_ARB_TIMING_BIT]
			|=> arbitration_lost_flag ##1 sda_oe_n [*2];
	endproperty
	a_arb_flag: assert property (p_arb_flag)
		else $error("arbitration loss not reported or released");

	property p_shift_empty;
		reg_read && reg_addr == two_wire_pkg::ADDR_CHANNEL_CTRL0
			|=> reg_rdata[two_wire_pkg::CC0_SHIFT_EMPTY_BIT]
				== ($past(state) == two_wire_pkg::ST_IDLE);
	endproperty
	a_shift_empty: assert property (p_shift_empty)
		else $error("shift empty flag wrong");

	property p_slave_no_pull;
		clock_external |-> scl_oe_n;
	endproperty
	a_slave_no_pull: assert property (p_slave_no_pull)
		else $error("slave drove the clock line");
endmodule

// File: test/two_wire_partner.sv
`timescale 1ns/100ps
module two_wire_partner (
	// system
	input  logic       clk_sys,
	input  logic       reset_n,
	// bus wires
	input  logic       scl,
	input  logic       sda,
	output logic       sda_rel,
	// behaviour
	input  logic       ack_en,
	input  logic [7:0] out_byte,
	output logic [7:0] got_byte
);
	logic [3:0] scl_sh;
	logic [3:0] cnt;

	// acts a few cycles after each clock edge, once the line has settled
	always @(posedge clk_sys)
	begin
		scl_sh <= {scl_sh[2:0], scl};
		if (!reset_n)
		begin
			cnt      <= 4'h0;
			sda_rel  <= 1'b1;
			got_byte <= 8'h00;
		end
		else if (scl_sh[3:2] == 2'b01)
		begin
			if (cnt < 4'h8)
				got_byte <= {got_byte[6:0], sda};
			// release after the unit is not a data clock
			cnt <= (cnt == 4'ha) ? 4'h0 : cnt + 4'h1;
		end
		else if (scl_sh[3:2] == 2'b10)
		begin
			if (cnt == 4'h8)
				sda_rel <= ~ack_en;
			else if (cnt == 4'h9)
			begin
				sda_rel <= 1'b1;
				cnt     <= 4'ha;
			end
			else
				sda_rel <= out_byte[3'h7 - cnt[2:0]];
		end
	end
endmodule

// File: test/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic        scl_out;
	logic        scl_oe_n;
	logic        sda_out;
	logic        sda_oe_n;
	logic        irq_request;
	logic        sda_rel;
	logic        sda_wire;
	logic        scl_drv = 1'b1;
	logic        scl_wire;
	logic        ack_en = 1'b1;
	logic [7:0]  out_byte = 8'hff;
	logic [7:0]  got_byte;
	logic        scl_prev = 1'b1;
	logic        sda_prev = 1'b1;
	logic [1:0]  scl_hist = 2'b11;
	logic [31:0] lfsr = 32'hce52_09a8;
	int          error_cnt = 0;
	int          compares = 0;
	int          falls = 0;
	int          cyc = 0;
	int          t_last = 0;
	int          t_prev = 0;
	int          divs[4] = '{1, 2, 8, 32};

	always #20 clk_sys = ~clk_sys;
	// wired-and data line, pull-up when all release
	assign sda_wire = sda_oe_n & sda_rel;
	// wired-and clock line, bench acts as the far clock source in slave runs
	assign scl_wire = scl_oe_n & scl_drv;

	two_wire_serial_mode dut_u (
		.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .scl_in(scl_wire), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .irq_request(irq_request)
	);

	two_wire_partner partner_u (
		.clk_sys(clk_sys), .reset_n(reset_n), .scl(scl_wire), .sda(sda_wire),
		.sda_rel(sda_rel), .ack_en(ack_en), .out_byte(out_byte), .got_byte(got_byte)
	);

	task wrap_up;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task timeout;
		error_cnt++;
		$display("BAD %0t wait ran out", $time);
		wrap_up();
	endtask

	task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %0t %s: %h not %h", $time, msg, seen, exp);
		end
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic logic [15:0] exp_rx(input logic [7:0] tx, input logic [7:0] other,
		input logic ack, input logic arb);
		return {4'h0, arb, 2'b00, ~ack, tx & other};
	endfunction

	// edge monitor for the line clock and data output
	always @(posedge clk_sys)
	begin
		cyc      <= cyc + 1;
		scl_prev <= scl_wire;
		sda_prev <= sda_oe_n;
		scl_hist <= {scl_hist[0], scl_wire};
		if (scl_prev && !scl_wire)
		begin
			falls  <= falls + 1;
			t_prev <= t_last;
			t_last <= cyc;
		end
		if (reset_n && sda_prev !== sda_oe_n)
		begin
			check(16'(scl_hist == 2'b00 && !scl_wire), 16'h0001, "data moved");
			check(16'({scl_out, sda_out}), 16'h0000, "line driven high");
		end
	end

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask

	task rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task wait_falls(input int target);
		int i;
		for (i = 0; i < 40000 && falls < target; i++)
			@(posedge clk_sys);
		if (falls < target)
			timeout();
	endtask

	task idle_check(input string msg);
		repeat (60) @(posedge clk_sys);
		check(16'(falls), 16'h0000, msg);
	endtask

	// one master byte: configure, load, wait for idle
	task xfer(input logic [7:0] n, input logic [1:0] src, input logic [7:0] tx,
		output int per);
		int base;
		int i;
		logic [15:0] d;
		base = falls;
		wr(two_wire_pkg::ADDR_BIT_RATE, n);
		wr(two_wire_pkg::ADDR_CHANNEL_CTRL0, {6'h20, src});
		wr(two_wire_pkg::ADDR_TWO_WIRE_CTRL, {3'h0, lfsr[8], 1'b1, lfsr[10:9], 1'b1});
		wr(two_wire_pkg::ADDR_TX_BUFFER, tx);
		wr(two_wire_pkg::ADDR_TX_RX_CONTROL, 8'h05);
		wait_falls(base + 3);
		per = t_last - t_prev;
		wait_falls(base + 9);
		for (i = 0; i < 3000; i++)
		begin
			rd(two_wire_pkg::ADDR_CHANNEL_CTRL0, d);
			if (d[3] === 1'b1)
				break;
		end
		if (d[3] !== 1'b1)
			timeout();
	endtask

	initial
	begin
		logic [15:0] d;
		logic [7:0]  tx;
		int          s;
		int          k;
		int          per[2];
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(two_wire_pkg::ADDR_SERIAL_MODE, d);
		check(d, {8'h00, two_wire_pkg::SERIAL_MODE_RESET}, "mode reset");
		rd(two_wire_pkg::ADDR_TX_RX_CONTROL, d);
		check(d, 16'h0002, "control reset");
		rd(two_wire_pkg::ADDR_CHANNEL_CTRL0, d);
		check(d, 16'h0008, "idle flag");
		rd(two_wire_pkg::ADDR_TX_BUFFER, d);
		check(d, 16'h0000, "write only read");
		wr(two_wire_pkg::ADDR_TX_RX_CONTROL, 8'h05);
		wr(two_wire_pkg::ADDR_TX_BUFFER, 8'h5a);
		wr(two_wire_pkg::ADDR_SERIAL_MODE, 8'h02);
		idle_check("start without mode select");
		wr(two_wire_pkg::ADDR_SERIAL_MODE, 8'h03);
		wr(two_wire_pkg::ADDR_TWO_WIRE_CTRL, 8'h09);
		idle_check("start with function 011");
		wr(two_wire_pkg::ADDR_TX_RX_CONTROL, 8'h00);
		wr(two_wire_pkg::ADDR_SERIAL_MODE, 8'h02);
		idle_check("start without allow");
		rd(two_wire_pkg::ADDR_SERIAL_MODE, d);
		check(d, 16'h0002, "mode readback");
		for (s = 0; s < 4; s++)
		begin
			for (k = 0; k < 2; k++)
			begin
				lfsr = lfsr_next(lfsr);
				tx = lfsr[7:0];
				ack_en <= lfsr[12];
				xfer(k ? 8'h0f : 8'h07, 2'(s), tx, per[k]);
				check(16'(got_byte), 16'(tx), "byte on wire");
				rd(two_wire_pkg::ADDR_RX_BUFFER, d);
				check(d, exp_rx(tx, 8'hff, lfsr[12], 1'b0), "receive word");
				check(16'(irq_request), 16'h0001, "no byte event");
				wr(two_wire_pkg::ADDR_RX_INT_CONTROL, 8'h00);
				@(posedge clk_sys);
				#1;
				check(16'(irq_request), 16'h0000, "event stuck");
			end
			check(16'(per[1] - per[0]), 16'(16 * divs[s]), "line clock rate");
		end
		// another party wins the bus on the first bit
		out_byte <= 8'h7f;
		ack_en   <= 1'b1;
		// per-bit timing first, then byte-end timing
		for (k = 0; k < 2; k++)
		begin
			lfsr[9] = k[0];
			xfer(8'h07, 2'h0, 8'hff, per[0]);
			rd(two_wire_pkg::ADDR_RX_BUFFER, d);
			check(d, exp_rx(8'hff, 8'h7f, 1'b1, 1'b1), "lost bus word");
		end
		out_byte <= 8'hff;
		ack_en   <= 1'b0;
		// second byte lands before the first is read
		xfer(8'h07, 2'h1, 8'hc3, per[0]);
		wr(two_wire_pkg::ADDR_RX_INT_CONTROL, 8'h00);
		xfer(8'h07, 2'h1, 8'h3c, per[0]);
		repeat (4) @(posedge clk_sys);
		check(16'(irq_request), 16'h0000, "overrun raised event");
		rd(two_wire_pkg::ADDR_RX_BUFFER, d);
		check(16'(d[12:11]), 16'h0002, "overrun flag");
		// slave: clock from the bus, start set up while it is high
		wr(two_wire_pkg::ADDR_TX_RX_CONTROL, 8'h00);
		wr(two_wire_pkg::ADDR_SERIAL_MODE, 8'h0a);
		wr(two_wire_pkg::ADDR_TX_BUFFER, 8'ha5);
		wr(two_wire_pkg::ADDR_TX_RX_CONTROL, 8'h05);
		repeat (10)
		begin
			repeat (16) @(posedge clk_sys);
			scl_drv <= 1'b0;
			check(16'(scl_oe_n), 16'h0001, "slave pulled clock");
			repeat (16) @(posedge clk_sys);
			scl_drv <= 1'b1;
		end
		repeat (16) @(posedge clk_sys);
		check(16'(got_byte), 16'h00a5, "slave byte on wire");
		rd(two_wire_pkg::ADDR_RX_BUFFER, d);
		check(d, exp_rx(8'ha5, 8'hff, 1'b0, 1'b0), "slave receive word");
		wrap_up();
	end
endmodule
